// ==== src/hpp_pkg.sv ====
/*
 host parallel port package: host address map, processor register map,
 field layouts, reset values and the pin carrier struct.
 assumes a single pclk domain and a 4-bit host address bus.
*/
package hpp_pkg;
	// ------------------------------------------------------------------
	// widths
	// ------------------------------------------------------------------
	localparam int HPP_DW = 16;
	localparam int HPP_AW = 4;
	localparam int HPP_PW = 10;
	localparam int HPP_NQ = 4;

	// ------------------------------------------------------------------
	// queue indices
	// ------------------------------------------------------------------
	localparam int HPP_Q_DLCMD = 0;
	localparam int HPP_Q_ULCMD = 1;
	localparam int HPP_Q_DLDAT = 2;
	localparam int HPP_Q_ULDAT = 3;

	// ------------------------------------------------------------------
	// host address map
	// ------------------------------------------------------------------
	localparam logic [3:0] HPP_HA_DLCMD = 4'h0;
	localparam logic [3:0] HPP_HA_ULCMD = 4'h1;
	localparam logic [3:0] HPP_HA_DLDAT = 4'h2;
	localparam logic [3:0] HPP_HA_ULDAT = 4'h3;
	localparam logic [3:0] HPP_HA_ULCNT = 4'h4;
	localparam logic [3:0] HPP_HA_DLFREE = 4'h5;
	localparam logic [3:0] HPP_HA_DLTHR = 4'h6;
	localparam logic [3:0] HPP_HA_ULTHR = 4'h7;
	localparam logic [3:0] HPP_HA_ISTS = 4'h8;
	localparam logic [3:0] HPP_HA_IMASK = 4'h9;
	localparam logic [3:0] HPP_HA_PWR = 4'ha;
	localparam logic [3:0] HPP_HA_BELL = 4'hb;

	// ------------------------------------------------------------------
	// processor (apb) register map, byte addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] HPP_RA_CMDRD = 8'h00;
	localparam logic [7:0] HPP_RA_CMDWR = 8'h04;
	localparam logic [7:0] HPP_RA_STAT = 8'h08;
	localparam logic [7:0] HPP_RA_ISTS = 8'h0c;
	localparam logic [7:0] HPP_RA_IMASK = 8'h10;
	localparam logic [7:0] HPP_RA_PWR = 8'h14;

	// ------------------------------------------------------------------
	// processor interrupt bits and reset values
	// ------------------------------------------------------------------
	localparam int HPP_IB_CMD = 0;
	localparam int HPP_IB_BELL = 1;
	localparam int HPP_IB_OVF = 2;
	localparam int HPP_IB_UNF = 3;
	localparam logic [9:0] HPP_DLTHR_RST = 10'h004;
	localparam logic [9:0] HPP_ULTHR_RST = 10'h1c0;
	localparam logic [1:0] HPP_HMASK_RST = 2'h3;
	localparam logic [3:0] HPP_IMASK_RST = 4'h0;
	localparam logic [15:0] HPP_PWR_RST = 16'h0000;

	// ------------------------------------------------------------------
	// carriers
	// ------------------------------------------------------------------
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic [HPP_AW-1:0] addr;
		logic [HPP_DW-1:0] data;
	} hpp_pins_t;

	typedef struct packed {
		logic [HPP_DW-1:0] data;
		logic valid;
	} hpp_word_t;
endpackage

// ==== src/hpp_port.sv ====
/*
 host parallel port: asynchronous 16-bit host bus onto four queues, host
 status/threshold/interrupt registers, apb slave for the processor, two dma
 streaming ports.
 assumes the host holds address and write data across its strobe and that
 strobes last at least three pclk periods.
*/
`timescale 1ns/1ps
// Contract
// - host bus is asynchronous, 16-bit data, separate read and write strobes
// - host address selects one of four queues
// - each download command entry interrupts the internal processor
// - 16x16 upload command queue; host interrupted while it is non-empty
// - 16x16 download data queue; host interrupted when almost empty
// - dma channel drains download data queue toward dram
// - 512x16 upload data queue; host interrupted when almost full
// - dma channel refills upload data queue whenever it has room
// - each data queue has its own dma channel, both run together
// - host status gives upload word count and download free space
// - host control sets queue thresholds for the data interrupt
// - two host interrupt sources: command queue and data queue
// - host mask register gates each source individually
// - host status register shows which queue interrupts
// - host reaches power registers and can interrupt the processor
module hpp_port
	import hpp_pkg::*;
#(
	parameter int CMD_DEPTH = 16,
	parameter int DL_DEPTH = 16,
	parameter int UL_DEPTH = 512
)
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// host pins
	input wire hpp_pkg::hpp_pins_t hp_pins,
	output logic [15:0] hp_data_out,
	output logic hp_data_oe,
	output logic hp_irq,
	// dma channels
	output hpp_pkg::hpp_word_t dma_dl,
	input wire logic dma_dl_ready,
	input wire hpp_pkg::hpp_word_t dma_ul,
	output logic dma_ul_ready,
	// processor side
	output logic cpu_irq,
	output logic [15:0] pwr_ctrl
);
	import hpp_pkg::*;

	// ------------------------------------------------------------------
	// state
	// ------------------------------------------------------------------
	typedef struct packed {
		hpp_pins_t sync1;
		hpp_pins_t sync2;
		logic rd_act;
		logic wr_act;
		logic [HPP_AW-1:0] wr_addr;
		logic [HPP_DW-1:0] wr_data;
		logic [HPP_DW-1:0] hp_rdata;
		logic [HPP_NQ-1:0][HPP_PW-1:0] wptr;
		logic [HPP_NQ-1:0][HPP_PW-1:0] rptr;
		logic [HPP_PW-1:0] dl_thr;
		logic [HPP_PW-1:0] ul_thr;
		logic [1:0] hmask;
		logic [15:0] pwr;
		logic [3:0] ists;
		logic [3:0] imask;
		logic [31:0] prdata;
	} hpp_state_t;

	hpp_state_t s_ff;
	hpp_state_t nxt_s;
	logic [HPP_NQ-1:0] push;
	logic [HPP_NQ-1:0] pop;
	logic [HPP_NQ-1:0] full;
	logic [HPP_NQ-1:0] empty;
	logic [HPP_NQ-1:0][HPP_PW-1:0] cnt;
	logic [HPP_NQ-1:0][HPP_PW-1:0] qdepth;
	logic [HPP_NQ-1:0][HPP_DW-1:0] wdata;
	logic [HPP_NQ-1:0][HPP_DW-1:0] head;
	logic rd_now;
	logic wr_now;
	logic rd_start;
	logic wr_end;
	logic apb_wr;
	logic apb_rd;
	logic apb_hit;
	logic [1:0] hsrc;
	logic [3:0] iev;

	// ------------------------------------------------------------------
	// queues
	// ------------------------------------------------------------------
	// pointers wrap at 2**HPP_PW, so every depth must divide that
	genvar gi;
	generate
		for (gi = 0; gi < HPP_NQ; gi++)
		begin : g_q
			localparam int D = (gi == HPP_Q_ULDAT) ? UL_DEPTH :
				(gi == HPP_Q_DLDAT) ? DL_DEPTH : CMD_DEPTH;
			logic [HPP_DW-1:0] mem [D];
			assign qdepth[gi] = HPP_PW'(D);
			assign cnt[gi] = s_ff.wptr[gi] - s_ff.rptr[gi];
			assign full[gi] = (cnt[gi] == qdepth[gi]);
			assign empty[gi] = (cnt[gi] == '0);
			assign head[gi] = mem[s_ff.rptr[gi][$clog2(D)-1:0]];
			always_ff @(posedge pclk)
			begin
				if (push[gi])
					mem[s_ff.wptr[gi][$clog2(D)-1:0]] <= wdata[gi];
			end
		end
	endgenerate

	// ------------------------------------------------------------------
	// host strobes and apb decode
	// ------------------------------------------------------------------
	assign rd_now = !s_ff.sync2.cs_n && !s_ff.sync2.rd_n;
	assign wr_now = !s_ff.sync2.cs_n && !s_ff.sync2.wr_n;
	assign rd_start = rd_now && !s_ff.rd_act;
	assign wr_end = !wr_now && s_ff.wr_act;
	assign apb_wr = psel && penable && pwrite;
	assign apb_rd = psel && penable && !pwrite;
	assign apb_hit = (paddr == HPP_RA_CMDRD) || (paddr == HPP_RA_CMDWR) ||
		(paddr == HPP_RA_STAT) || (paddr == HPP_RA_ISTS) ||
		(paddr == HPP_RA_IMASK) || (paddr == HPP_RA_PWR);

	// almost-empty download data or almost-full upload data raise the data source
	assign hsrc[0] = !empty[HPP_Q_ULCMD];
	assign hsrc[1] = (cnt[HPP_Q_DLDAT] <= s_ff.dl_thr) ||
		(cnt[HPP_Q_ULDAT] >= s_ff.ul_thr);

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb
	begin
		nxt_s = s_ff;
		push = '0;
		pop = '0;
		wdata = '0;
		iev = '0;
		nxt_s.sync1 = hp_pins;
		nxt_s.sync2 = s_ff.sync1;
		nxt_s.rd_act = rd_now;
		nxt_s.wr_act = wr_now;
		// data and address latched through the strobe, acted on at its end
		if (wr_now)
		begin
			nxt_s.wr_addr = s_ff.sync2.addr;
			nxt_s.wr_data = s_ff.sync2.data;
		end
		if (rd_start)
		begin
			case (s_ff.sync2.addr)
				HPP_HA_ULCMD:
				begin
					nxt_s.hp_rdata = empty[HPP_Q_ULCMD] ? '0 : head[HPP_Q_ULCMD];
					pop[HPP_Q_ULCMD] = !empty[HPP_Q_ULCMD];
					iev[HPP_IB_UNF] = empty[HPP_Q_ULCMD];
				end
				HPP_HA_ULDAT:
				begin
					nxt_s.hp_rdata = empty[HPP_Q_ULDAT] ? '0 : head[HPP_Q_ULDAT];
					pop[HPP_Q_ULDAT] = !empty[HPP_Q_ULDAT];
					iev[HPP_IB_UNF] = empty[HPP_Q_ULDAT];
				end
				HPP_HA_ULCNT: nxt_s.hp_rdata = HPP_DW'(cnt[HPP_Q_ULDAT]);
				HPP_HA_DLFREE: nxt_s.hp_rdata =
					HPP_DW'(qdepth[HPP_Q_DLDAT] - cnt[HPP_Q_DLDAT]);
				HPP_HA_DLTHR: nxt_s.hp_rdata = HPP_DW'(s_ff.dl_thr);
				HPP_HA_ULTHR: nxt_s.hp_rdata = HPP_DW'(s_ff.ul_thr);
				HPP_HA_ISTS: nxt_s.hp_rdata = {14'h0000, hsrc & s_ff.hmask};
				HPP_HA_IMASK: nxt_s.hp_rdata = {14'h0000, s_ff.hmask};
				HPP_HA_PWR: nxt_s.hp_rdata = s_ff.pwr;
				default: nxt_s.hp_rdata = '0;
			endcase
		end
		if (wr_end)
		begin
			case (s_ff.wr_addr)
				HPP_HA_DLCMD:
				begin
					push[HPP_Q_DLCMD] = !full[HPP_Q_DLCMD];
					iev[HPP_IB_CMD] = !full[HPP_Q_DLCMD];
					iev[HPP_IB_OVF] = full[HPP_Q_DLCMD];
				end
				HPP_HA_DLDAT:
				begin
					push[HPP_Q_DLDAT] = !full[HPP_Q_DLDAT];
					iev[HPP_IB_OVF] = full[HPP_Q_DLDAT];
				end
				HPP_HA_DLTHR: nxt_s.dl_thr = s_ff.wr_data[HPP_PW-1:0];
				HPP_HA_ULTHR: nxt_s.ul_thr = s_ff.wr_data[HPP_PW-1:0];
				HPP_HA_IMASK: nxt_s.hmask = s_ff.wr_data[1:0];
				HPP_HA_PWR: nxt_s.pwr = s_ff.wr_data;
				HPP_HA_BELL: iev[HPP_IB_BELL] = 1'b1;
				default: ;
			endcase
		end
		wdata[HPP_Q_DLCMD] = s_ff.wr_data;
		wdata[HPP_Q_DLDAT] = s_ff.wr_data;
		wdata[HPP_Q_ULCMD] = pwdata[HPP_DW-1:0];
		wdata[HPP_Q_ULDAT] = dma_ul.data;
		// dma channels run independently of each other and of the host
		pop[HPP_Q_DLDAT] = dma_dl_ready && !empty[HPP_Q_DLDAT];
		push[HPP_Q_ULDAT] = dma_ul.valid && !full[HPP_Q_ULDAT];
		// apb: read data set up in the setup phase, side effects on access
		if (psel && !penable)
		begin
			case (paddr)
				// an empty queue reads as zero rather than a stale or unwritten entry
				HPP_RA_CMDRD: nxt_s.prdata = empty[HPP_Q_DLCMD] ? '0 :
					{16'h0000, head[HPP_Q_DLCMD]};
				HPP_RA_STAT: nxt_s.prdata = {6'h00, cnt[HPP_Q_ULCMD], 6'h00,
					cnt[HPP_Q_DLCMD]};
				HPP_RA_ISTS: nxt_s.prdata = {28'h0000000, s_ff.ists};
				HPP_RA_IMASK: nxt_s.prdata = {28'h0000000, s_ff.imask};
				HPP_RA_PWR: nxt_s.prdata = {16'h0000, s_ff.pwr};
				default: nxt_s.prdata = '0;
			endcase
		end
		if (apb_rd && paddr == HPP_RA_CMDRD)
			pop[HPP_Q_DLCMD] = !empty[HPP_Q_DLCMD];
		if (apb_wr && paddr == HPP_RA_CMDWR)
			push[HPP_Q_ULCMD] = !full[HPP_Q_ULCMD];
		if (apb_wr && paddr == HPP_RA_IMASK)
			nxt_s.imask = pwdata[3:0];
		// a new event wins over a write-one clear in the same cycle
		if (apb_wr && paddr == HPP_RA_ISTS)
			nxt_s.ists = s_ff.ists & ~pwdata[3:0];
		nxt_s.ists = nxt_s.ists | iev;
		for (int i = 0; i < HPP_NQ; i++)
		begin
			nxt_s.wptr[i] = s_ff.wptr[i] + HPP_PW'(push[i]);
			nxt_s.rptr[i] = s_ff.rptr[i] + HPP_PW'(pop[i]);
		end
	end

	// ------------------------------------------------------------------
	// registers
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_ff <= '0;
			s_ff.sync1 <= '1;
			s_ff.sync2 <= '1;
			s_ff.dl_thr <= HPP_DLTHR_RST;
			s_ff.ul_thr <= HPP_ULTHR_RST;
			s_ff.hmask <= HPP_HMASK_RST;
			s_ff.imask <= HPP_IMASK_RST;
			s_ff.pwr <= HPP_PWR_RST;
		end
		else
			s_ff <= nxt_s;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	assign prdata = s_ff.prdata;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !apb_hit;
	assign hp_data_out = s_ff.hp_rdata;
	assign hp_data_oe = s_ff.rd_act;
	assign hp_irq = |(hsrc & s_ff.hmask);
	assign cpu_irq = |(s_ff.ists & s_ff.imask);
	assign dma_dl.data = head[HPP_Q_DLDAT];
	assign dma_dl.valid = !empty[HPP_Q_DLDAT];
	assign dma_ul_ready = !full[HPP_Q_ULDAT];
	assign pwr_ctrl = s_ff.pwr;

	// ------------------------------------------------------------------
	// checks
	// ------------------------------------------------------------------
	sequence host_wr_s(logic [3:0] a);
		wr_end && s_ff.wr_addr == a;
	endsequence
	sequence host_rd_s(logic [3:0] a);
		rd_start && s_ff.sync2.addr == a;
	endsequence

	full_write_drop_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_wr_s(HPP_HA_DLCMD) ##0 full[HPP_Q_DLCMD] |=> $stable(s_ff.wptr[HPP_Q_DLCMD]))
		else $error("write to full command queue moved pointer");
	empty_read_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_rd_s(HPP_HA_ULCMD) ##0 empty[HPP_Q_ULCMD] |=> $stable(s_ff.rptr[HPP_Q_ULCMD]))
		else $error("read of empty upload queue moved pointer");
	one_push_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_wr_s(HPP_HA_DLDAT) ##0 !full[HPP_Q_DLDAT] ##0 !dma_dl_ready |=>
		cnt[HPP_Q_DLDAT] == $past(cnt[HPP_Q_DLDAT]) + 10'h001 ##1
		$stable(s_ff.wptr[HPP_Q_DLDAT]))
		else $error("host write did not push exactly once");
	cmd_irq_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_wr_s(HPP_HA_DLCMD) ##0 !full[HPP_Q_DLCMD] ##0 s_ff.imask[HPP_IB_CMD]
		|=> s_ff.ists[HPP_IB_CMD] && cpu_irq)
		else $error("command entry did not interrupt processor");
	bell_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_wr_s(HPP_HA_BELL) |=> s_ff.ists[HPP_IB_BELL])
		else $error("host doorbell lost");
	ulcmd_irq_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ff.hmask[0] && $past(apb_wr && paddr == HPP_RA_CMDWR) |-> hp_irq)
		else $error("upload command did not interrupt host");
	mask_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
		s_ff.hmask == 2'h0 |-> !hp_irq)
		else $error("masked source reached host");
	ul_refill_a: assert property (@(posedge pclk) disable iff (!presetn)
		dma_ul.valid && dma_ul_ready && !rd_start |=>
		cnt[HPP_Q_ULDAT] == $past(cnt[HPP_Q_ULDAT]) + 10'h001)
		else $error("upload data refill not taken");
	strobe_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
		$fell(s_ff.sync1.rd_n) && !s_ff.sync1.cs_n |-> !hp_data_oe ##1 !hp_data_oe)
		else $error("read strobe acted before synchronisation");
	thr_write_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_wr_s(HPP_HA_DLTHR) |=> s_ff.dl_thr == $past(s_ff.wr_data[HPP_PW-1:0]))
		else $error("threshold write not taken");
	dl_drain_a: assert property (@(posedge pclk) disable iff (!presetn)
		dma_dl.valid && dma_dl_ready && !wr_end |=>
		cnt[HPP_Q_DLDAT] == $past(cnt[HPP_Q_DLDAT]) - 10'h001)
		else $error("download data word not drained");
	ul_pop_once_a: assert property (@(posedge pclk) disable iff (!presetn)
		host_rd_s(HPP_HA_ULDAT) ##0 !empty[HPP_Q_ULDAT] ##0 !dma_ul.valid |=>
		cnt[HPP_Q_ULDAT] == $past(cnt[HPP_Q_ULDAT]) - 10'h001 ##1
		$stable(s_ff.rptr[HPP_Q_ULDAT]))
		else $error("host read did not pop exactly once");
	cmd_empty_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		apb_rd && paddr == HPP_RA_CMDRD && empty[HPP_Q_DLCMD] |=>
		$stable(s_ff.rptr[HPP_Q_DLCMD]))
		else $error("read of empty command queue moved pointer");
endmodule

// ==== verif/hpp_host_model.sv ====
/*
 behavioural external host on the asynchronous 16-bit parallel port.
 assumes the device drives the data pins only while hp_data_oe is high.
*/
`timescale 1ns/1ps
module hpp_host_model
	import hpp_pkg::*;
(
	// clock used only to pace the strobes
	input wire logic pclk,
	// device read-back
	input wire logic [15:0] hp_data_out,
	input wire logic hp_data_oe,
	// host pins
	output hpp_pkg::hpp_pins_t hp_pins
);
	import hpp_pkg::*;

	logic cs_n = 1'b1;
	logic rd_n = 1'b1;
	logic wr_n = 1'b1;
	logic [3:0] addr = 4'h0;
	logic [15:0] drv = 16'h0;

	// released bus shows the inverted last value, so a stale word never matches
	assign hp_pins = {cs_n, rd_n, wr_n, addr, hp_data_oe ? hp_data_out : drv};

	task automatic gap(input int n);
		repeat (n) @(posedge pclk);
	endtask

	// strobes low 4 and high 8 cycles between writes, addr/data held 2 around them
	task automatic write(input logic [3:0] a, input logic [15:0] d);
		@(posedge pclk);
		cs_n <= 1'b0;
		addr <= a;
		drv <= d;
		gap(2);
		wr_n <= 1'b0;
		gap(4);
		wr_n <= 1'b1;
		gap(2);
		cs_n <= 1'b1;
		drv <= ~d;
		gap(3);
	endtask

	task automatic read(input logic [3:0] a, output logic [15:0] d);
		@(posedge pclk);
		cs_n <= 1'b0;
		addr <= a;
		gap(2);
		rd_n <= 1'b0;
		gap(5);
		d = hp_pins.data;
		rd_n <= 1'b1;
		gap(2);
		cs_n <= 1'b1;
		gap(3);
	endtask
endmodule

// ==== verif/hpp_port_tb.sv ====
/*
 self-checking bench for hpp_port: apb master, host model, dma stubs.
 assumes zero-wait apb and the host timing of hpp_host_model.
*/
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
	begin \
		samples_checked++; \
		if ((got) !== (ex)) \
		begin \
			err_total++; \
			$display("wrong value %s exp %h got %h", nm, ex, got); \
		end \
	end
module hpp_port_tb;
	import hpp_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, r;
	hpp_pins_t hp_pins;
	logic [15:0] hp_data_out, pwr_ctrl, h;
	logic hp_data_oe, hp_irq, dma_dl_ready, dma_ul_ready, cpu_irq;
	hpp_word_t dma_dl, dma_ul;
	int err_total = 0;
	int samples_checked = 0;

	hpp_port DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .hp_pins(hp_pins), .hp_data_out(hp_data_out),
		.hp_data_oe(hp_data_oe), .hp_irq(hp_irq), .dma_dl(dma_dl),
		.dma_dl_ready(dma_dl_ready), .dma_ul(dma_ul), .dma_ul_ready(dma_ul_ready),
		.cpu_irq(cpu_irq), .pwr_ctrl(pwr_ctrl));
	hpp_host_model u_host (.pclk(pclk), .hp_data_out(hp_data_out),
		.hp_data_oe(hp_data_oe), .hp_pins(hp_pins));

	initial
	begin
		pclk = 1'b0;
		forever #25 pclk = ~pclk;
	end

	task automatic give_verdict;
		if (err_total == 0 && samples_checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1 && n < 50)
		begin
			@(posedge pclk);
			n++;
		end
		if (n == 50)
			err_total++;
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic t_reset;
		@(negedge pclk);
		`CHK("hp_irq", 1'b1, hp_irq);
		`CHK("cpu_irq", 1'b0, cpu_irq);
		`CHK("ul_ready", 1'b1, dma_ul_ready);
		`CHK("dl_valid", 1'b0, dma_dl.valid);
		apb(1'b0, HPP_RA_IMASK, 32'h0);
		`CHK("imask", 32'h0, r);
		u_host.read(HPP_HA_IMASK, h);
		`CHK("hmask", 16'h3, h);
		u_host.read(HPP_HA_DLTHR, h);
		`CHK("dlthr", 16'h4, h);
		u_host.read(HPP_HA_ULTHR, h);
		`CHK("ulthr", 16'h1c0, h);
		u_host.read(HPP_HA_DLFREE, h);
		`CHK("dlfree", 16'h10, h);
	endtask

	// one more than fits: the overflow word must vanish, the rest stay in order
	task automatic t_dlcmd;
		apb(1'b1, HPP_RA_IMASK, 32'hf);
		for (int i = 0; i < 17; i++)
			u_host.write(HPP_HA_DLCMD, 16'ha000 + 16'(i));
		@(negedge pclk);
		`CHK("cpu_irq", 1'b1, cpu_irq);
		apb(1'b0, HPP_RA_ISTS, 32'h0);
		`CHK("ists", 32'h5, r);
		apb(1'b0, HPP_RA_STAT, 32'h0);
		`CHK("stat", 32'h10, r);
		for (int i = 0; i < 16; i++)
		begin
			apb(1'b0, HPP_RA_CMDRD, 32'h0);
			`CHK("cmd", 32'ha000 + 32'(i), r);
		end
		apb(1'b0, HPP_RA_CMDRD, 32'h0);
		`CHK("cmd_empty", 32'h0, r);
		apb(1'b0, HPP_RA_STAT, 32'h0);
		`CHK("stat_empty", 32'h0, r);
		apb(1'b1, HPP_RA_ISTS, 32'hf);
		@(negedge pclk);
		`CHK("cpu_irq", 1'b0, cpu_irq);
	endtask

	task automatic t_ulcmd;
		u_host.write(HPP_HA_IMASK, 16'h1);
		@(negedge pclk);
		`CHK("hp_irq", 1'b0, hp_irq);
		apb(1'b1, HPP_RA_CMDWR, 32'h5a5a);
		apb(1'b1, HPP_RA_CMDWR, 32'h0c3c);
		@(negedge pclk);
		`CHK("hp_irq", 1'b1, hp_irq);
		u_host.read(HPP_HA_ISTS, h);
		`CHK("hists", 16'h1, h);
		u_host.read(HPP_HA_ULCMD, h);
		`CHK("ulcmd", 16'h5a5a, h);
		u_host.read(HPP_HA_ULCMD, h);
		`CHK("ulcmd", 16'h0c3c, h);
		`CHK("hp_irq", 1'b0, hp_irq);
		u_host.read(HPP_HA_ULCMD, h);
		`CHK("empty", 16'h0, h);
		apb(1'b0, HPP_RA_ISTS, 32'h0);
		`CHK("ists", 32'h8, r);
		apb(1'b1, HPP_RA_ISTS, 32'hf);
	endtask

	// drain one word at a time, level 4 crossed between the 2nd and 3rd pop
	task automatic t_dldata;
		u_host.write(HPP_HA_IMASK, 16'h2);
		for (int i = 0; i < 6; i++)
			u_host.write(HPP_HA_DLDAT, 16'hd000 + 16'(i));
		u_host.read(HPP_HA_DLFREE, h);
		`CHK("dlfree", 16'ha, h);
		u_host.read(HPP_HA_ISTS, h);
		`CHK("hists", 16'h0, h);
		for (int i = 0; i < 6; i++)
		begin
			@(negedge pclk);
			`CHK("dl_ae", (i >= 2), hp_irq);
			`CHK("dl_valid", 1'b1, dma_dl.valid);
			`CHK("dl_data", 16'hd000 + 16'(i), dma_dl.data);
			@(posedge pclk);
			dma_dl_ready <= 1'b1;
			@(posedge pclk);
			dma_dl_ready <= 1'b0;
		end
		@(negedge pclk);
		`CHK("dl_valid", 1'b0, dma_dl.valid);
	endtask

	// a download word stays parked so only the upload level drives the source
	task automatic t_uldata;
		u_host.write(HPP_HA_DLTHR, 16'h0);
		u_host.write(HPP_HA_ULTHR, 16'h3);
		u_host.write(HPP_HA_DLDAT, 16'h1234);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge pclk);
			dma_ul <= '{data: 16'hb000 + 16'(i), valid: (i < 3)};
			@(negedge pclk);
			`CHK("ul_af", (i == 3), hp_irq);
		end
		u_host.read(HPP_HA_ULCNT, h);
		`CHK("ulcnt", 16'h3, h);
		`CHK("ul_ready", 1'b1, dma_ul_ready);
		`CHK("dl_valid", 1'b1, dma_dl.valid);
		for (int i = 0; i < 3; i++)
		begin
			u_host.read(HPP_HA_ULDAT, h);
			`CHK("uldat", 16'hb000 + 16'(i), h);
		end
		@(posedge pclk);
		dma_dl_ready <= 1'b1;
		@(posedge pclk);
		dma_dl_ready <= 1'b0;
		@(negedge pclk);
		`CHK("dl_valid", 1'b0, dma_dl.valid);
	endtask

	task automatic t_misc;
		u_host.write(HPP_HA_BELL, 16'h1);
		apb(1'b0, HPP_RA_ISTS, 32'h0);
		`CHK("bell", 32'h2, r);
		@(negedge pclk);
		`CHK("cpu_irq", 1'b1, cpu_irq);
		apb(1'b1, HPP_RA_IMASK, 32'h0);
		@(negedge pclk);
		`CHK("cpu_irq", 1'b0, cpu_irq);
		apb(1'b1, HPP_RA_ISTS, 32'hf);
		apb(1'b0, HPP_RA_ISTS, 32'h0);
		`CHK("ists", 32'h0, r);
		u_host.write(HPP_HA_PWR, 16'hbeef);
		@(negedge pclk);
		`CHK("pwr", 16'hbeef, pwr_ctrl);
		apb(1'b0, HPP_RA_PWR, 32'h0);
		`CHK("pwr_rd", 32'hbeef, r);
		u_host.read(HPP_HA_PWR, h);
		`CHK("hpwr", 16'hbeef, h);
		// download queue empty at level 0 keeps the data source up until masked
		`CHK("hp_irq", 1'b1, hp_irq);
		u_host.write(HPP_HA_IMASK, 16'h0);
		@(negedge pclk);
		`CHK("hp_irq_masked", 1'b0, hp_irq);
		apb(1'b0, 8'h3c, 32'h0);
		`CHK("slverr", 1'b1, e);
		`CHK("unmapped", 32'h0, r);
	endtask

	// under a thousand cycles expected; generous margin
	initial
	begin
		repeat (20000) @(posedge pclk);
		err_total++;
		give_verdict;
	end

	initial
	begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h0;
		pwdata = 32'h0;
		dma_dl_ready = 1'b0;
		dma_ul = '0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_reset;
		t_dlcmd;
		t_ulcmd;
		t_dldata;
		t_uldata;
		t_misc;
		give_verdict;
	end
endmodule
